// [mgmt_master.sv]
// APB master standing in for the MAC-side management controller.
// Assumes one pclk domain; the bench calls xfer after a rising or a falling edge.
module mgmt_master (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
   end

   // One transfer: setup, then access held until pready is seen high at a
   // rising edge; the answer is taken at that edge, before the slave moves on
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err, output logic ok);
      ok = 1'b0;
      rd = 32'h0000_0000;
      err = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      // Bounded wait; the bench reports a stall
      for (int n = 0; n < 16 && !ok; n++) begin
         @(posedge pclk);
         if (pready) begin
            ok = 1'b1;
            rd = prdata;
            err = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : mgmt_master

// [phy_event_defs.svh]
// Constants for the PHY event flag, mask and link-result status block.
// Assumes it is included by the package and the top module by bare name.
// Function
// - Energy appearing sets flag bit 7
// - Negotiation complete sets flag bit 6
// - Remote fault from partner sets bit 5
// - Link going down sets flag bit 4
// - Partner acknowledge received sets bit 3
// - Parallel detection fault sets flag bit 2
// - Negotiation page received sets flag bit 1
// - Flags latch high, clear on read or write-one; reserved read zero
// - Link-down flag takes present line state at first enabled cycle
// - Mask bits 7-0 enable sources, reset zero
// - Mask bits 15-8 read zero, written zero
// - Status bit 12 shows negotiation done
// - Bits 4-2 report resolved speed and duplex
// - Status bits 11-5 reset to 0000010
// - Status bits 15-13, 1-0 read zero
// - Energy indication drops after 256 ms quiet
`ifndef PHY_EVENT_DEFS_SVH
`define PHY_EVENT_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_EVENT_FLAGS 6'h1d
`define IDX_EVENT_MASK 6'h1e
`define IDX_LINK_STATUS 6'h1f

// Event flag bit positions
`define FLAG_W 8
`define ENERGY_EVENT_FLAG_BIT 7
`define NEGOTIATION_COMPLETE_FLAG_BIT 6
`define REMOTE_FAULT_FLAG_BIT 5
`define LINK_DOWN_FLAG_BIT 4
`define PARTNER_ACK_FLAG_BIT 3
`define PARALLEL_DETECT_FAULT_FLAG_BIT 2
`define PAGE_RECEIVED_FLAG_BIT 1
`define RESERVED_FLAG_BIT 0

// Link-result status fields
`define AUTODONE_BIT 12
`define SPEED_MSB 4
`define SPEED_LSB 2
`define CTL_MSB 11
`define CTL_LSB 5
`define CTL_LANE0_W 3
`define CTL_LANE1_W 4

// Reset values and speed codes
`define FLAGS_RST 8'h00
`define MASK_RST 8'h00
`define CTL_RST 7'h02
`define SPEED_RST 3'h0
`define SPEED_10_HALF 3'h1
`define SPEED_10_FULL 3'h5
`define SPEED_100_HALF 3'h2
`define SPEED_100_FULL 3'h6

// Timing
`define ENERGY_WINDOW_MS 256
`define PCLK_HZ 20000000
`define MS_PER_S 1000

`endif

// [phy_event_flag_mask_status.sv]
// Event flags, event mask and link-result status of the PHY, as an APB slave.
// Assumes all event and status inputs come from PHY logic on pclk, so no
// synchroniser is placed on them; pulses are one pclk cycle wide.
`include "phy_event_defs.svh"

module phy_event_flag_mask_status
   import phy_event_pkg::*;
#(
   parameter int ADDR_W               = 8,
   parameter int ENERGY_WINDOW_CYCLES = `ENERGY_WINDOW_MS * (`PCLK_HZ / `MS_PER_S)
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              energy_seen,
   input  wire logic              an_done,
   input  wire logic              remote_fault,
   input  wire logic              partner_ack,
   input  wire logic              parallel_fault,
   input  wire logic              page_received,
   input  wire logic              link_up,
   input  wire logic              res_speed_100,
   input  wire logic              res_full_duplex,
   output logic                   energy_present,
   output logic                   phy_irq
);

   localparam int CNT_W = $clog2(ENERGY_WINDOW_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ENERGY_WINDOW_CYCLES - 1);
   localparam int CTL_W = `CTL_MSB - `CTL_LSB + 1;
   localparam flag_vec_t FLAG_RST_VEC = `FLAGS_RST;

   run_state_t        state_reg;
   flag_vec_t         flags_reg;
   flag_vec_t         mask_reg;
   flag_vec_t         set_ev;
   flag_vec_t         hold_ev;
   flag_vec_t         clr_req;
   logic [CTL_W-1:0]  ctl_reg;
   logic [CTL_W-1:0]  ctl_next;
   logic [CTL_W-1:0]  ctl_lanes;
   logic [2:0]        speed_reg;
   logic [2:0]        speed_code;
   logic              autodone_reg;
   logic              link_up_reg;
   logic              energy_reg;
   logic [CNT_W-1:0]  quiet_cnt_reg;
   logic              energy_rise;
   logic              loaded_reg;
   logic [31:0]       prdata_reg;
   logic              pslverr_reg;
   logic [31:0]       rd_word;
   logic [15:0]       status_word;
   logic              hit_flags;
   logic              hit_mask;
   logic              hit_stat;
   logic              mapped;
   logic              xfer_done;
   logic              wr_done;
   logic              rd_done;
   logic              running;

   // Address decode against four times each register index
   assign hit_flags = (paddr == ADDR_W'({`IDX_EVENT_FLAGS, 2'b00}));
   assign hit_mask  = (paddr == ADDR_W'({`IDX_EVENT_MASK, 2'b00}));
   assign hit_stat  = (paddr == ADDR_W'({`IDX_LINK_STATUS, 2'b00}));
   assign mapped    = hit_flags | hit_mask | hit_stat;
   assign running   = (state_reg == st_run);

   // Ready only once read data is held in flops; a frozen block never answers
   assign pready    = ce & loaded_reg;
   assign xfer_done = psel & penable & pready;
   assign wr_done   = xfer_done & pwrite & ~pslverr_reg;
   assign rd_done   = xfer_done & ~pwrite & ~pslverr_reg;
   assign prdata    = prdata_reg;
   assign pslverr   = pslverr_reg;

   // Start-up: the first enabled cycle after reset captures the line state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= st_init;
      end else if (ce) begin
         case (state_reg)
            st_init: state_reg <= st_run;
            st_run:  state_reg <= st_run;
            default: state_reg <= st_init;
         endcase
      end
   end

   // Status inputs tracked once per cycle for edge detection and readback
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_up_reg  <= 1'b0;
         autodone_reg <= 1'b0;
         speed_reg    <= `SPEED_RST;
      end else if (ce) begin
         link_up_reg  <= link_up;
         autodone_reg <= an_done;
         speed_reg    <= speed_code;
      end
   end

   // Resolved speed and duplex encoding
   always_comb begin
      case ({res_full_duplex, res_speed_100})
         2'b00:   speed_code = `SPEED_10_HALF;
         2'b10:   speed_code = `SPEED_10_FULL;
         2'b01:   speed_code = `SPEED_100_HALF;
         2'b11:   speed_code = `SPEED_100_FULL;
         default: speed_code = `SPEED_RST;
      endcase
   end

   // Energy indication: high from reset, low after a full quiet window.
   // The counter parks at its last value so a long silence cannot wrap.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         energy_reg    <= 1'b1;
         quiet_cnt_reg <= '0;
      end else if (ce) begin
         if (energy_seen) begin
            energy_reg    <= 1'b1;
            quiet_cnt_reg <= '0;
         end else if (energy_reg) begin
            if (quiet_cnt_reg == CNT_LAST) begin
               energy_reg <= 1'b0;
            end else begin
               quiet_cnt_reg <= CNT_W'(quiet_cnt_reg + 1'b1);
            end
         end
      end
   end

   assign energy_present = energy_reg;
   assign energy_rise    = energy_seen & ~energy_reg;

   // Event sources; none fires during the start-up capture cycle, when the link-down flag takes the line state
   always_comb begin
      set_ev = '0;
      if (running) begin
         set_ev[`ENERGY_EVENT_FLAG_BIT]          = energy_rise;
         set_ev[`NEGOTIATION_COMPLETE_FLAG_BIT]  = an_done & ~autodone_reg;
         set_ev[`REMOTE_FAULT_FLAG_BIT]          = remote_fault;
         set_ev[`LINK_DOWN_FLAG_BIT]             = link_up_reg & ~link_up;
         set_ev[`PARTNER_ACK_FLAG_BIT]           = partner_ack;
         set_ev[`PARALLEL_DETECT_FAULT_FLAG_BIT] = parallel_fault;
         set_ev[`PAGE_RECEIVED_FLAG_BIT]         = page_received;
      end
   end

   // A cause still present keeps its flag; link down is a lasting cause
   always_comb begin
      hold_ev = set_ev;
      hold_ev[`LINK_DOWN_FLAG_BIT] = set_ev[`LINK_DOWN_FLAG_BIT] | (running & ~link_up);
   end

   // Clear only the bits that were actually returned, so an event landing
   // between data capture and completion is never lost. Write-one also clears.
   always_comb begin
      clr_req = '0;
      if (rd_done && hit_flags) begin
         clr_req = prdata_reg[`FLAG_W-1:0];
      end else if (wr_done && hit_flags && pstrb[0]) begin
         clr_req = pwdata[`FLAG_W-1:0];
      end
   end

   // One latching flop per flag bit; set wins over any clear
   for (genvar i = 0; i < `FLAG_W; i++) begin : g_flag
      logic bit_q;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            bit_q <= FLAG_RST_VEC[i];
         end else if (ce) begin
            if (!running && (i == `LINK_DOWN_FLAG_BIT)) begin
               bit_q <= ~link_up;
            end else if (set_ev[i]) begin
               bit_q <= 1'b1;
            end else if (clr_req[i] && !hold_ev[i]) begin
               bit_q <= 1'b0;
            end
         end
      end
      assign flags_reg[i] = bit_q;
   end

   // Mask register: low byte only, upper byte is not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= `MASK_RST;
      end else if (ce && wr_done && hit_mask && pstrb[0]) begin
         mask_reg <= pwdata[`FLAG_W-1:0];
      end
   end

   // Stored status field, written per byte lane
   always_comb begin
      ctl_lanes = {{`CTL_LANE1_W{pstrb[1]}}, {`CTL_LANE0_W{pstrb[0]}}};
      ctl_next  = (ctl_reg & ~ctl_lanes) | (pwdata[`CTL_MSB:`CTL_LSB] & ctl_lanes);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= `CTL_RST;
      end else if (ce && wr_done && hit_stat) begin
         ctl_reg <= ctl_next;
      end
   end

   // Status word; reserved bits stay zero
   always_comb begin
      status_word = '0;
      status_word[`AUTODONE_BIT]         = autodone_reg;
      status_word[`CTL_MSB:`CTL_LSB]     = ctl_reg;
      status_word[`SPEED_MSB:`SPEED_LSB] = speed_reg;
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_word = '0;
      if (hit_flags) begin
         rd_word[`FLAG_W-1:0] = flags_reg;
      end else if (hit_mask) begin
         rd_word[`FLAG_W-1:0] = mask_reg;
      end else if (hit_stat) begin
         rd_word[15:0] = status_word;
      end
   end

   // Read data and error captured once per transfer, then held until done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_reg  <= 1'b0;
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else if (ce) begin
         if (xfer_done) begin
            loaded_reg <= 1'b0;
         end else if (psel && !loaded_reg) begin
            loaded_reg  <= 1'b1;
            pslverr_reg <= ~mapped;
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_word;
         end
      end
   end

   // Level interrupt from unmasked flags
   assign phy_irq = |(flags_reg & mask_reg);

   a_energy_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && running && energy_seen && !energy_reg
      |=> flags_reg[`ENERGY_EVENT_FLAG_BIT] && energy_reg)
      else $error("energy flag not set on energy return");

   a_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && running && an_done && !autodone_reg
      |=> flags_reg[`NEGOTIATION_COMPLETE_FLAG_BIT] && autodone_reg)
      else $error("negotiation complete flag not set");

   a_fault_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && running && remote_fault |=> flags_reg[`REMOTE_FAULT_FLAG_BIT])
      else $error("remote fault flag not set");

   a_link_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && running && link_up_reg && !link_up
      |=> flags_reg[`LINK_DOWN_FLAG_BIT])
      else $error("link down flag not set");

   a_ack_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && running && partner_ack |=> flags_reg[`PARTNER_ACK_FLAG_BIT])
      else $error("partner acknowledge flag not set");

   a_pd_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && running && parallel_fault
      |=> flags_reg[`PARALLEL_DETECT_FAULT_FLAG_BIT])
      else $error("parallel detection fault flag not set");

   a_page_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && running && page_received |=> flags_reg[`PAGE_RECEIVED_FLAG_BIT])
      else $error("page received flag not set");

   a_flags_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      !flags_reg[`RESERVED_FLAG_BIT]
      && (!(rd_done && hit_flags) || prdata[31:`FLAG_W] == '0))
      else $error("reserved flag bits not zero");

   a_flag_latches: assert property (@(posedge pclk) disable iff (!presetn)
      flags_reg[`REMOTE_FAULT_FLAG_BIT] && !(rd_done && hit_flags) && !wr_done
      |=> flags_reg[`REMOTE_FAULT_FLAG_BIT])
      else $error("flag dropped without a clearing access");

   a_init_link: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !running |=> flags_reg[`LINK_DOWN_FLAG_BIT] == !$past(link_up))
      else $error("link down flag does not follow line state at start");

   a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr_done && hit_mask && pstrb[0]
      |=> mask_reg == $past(pwdata[`FLAG_W-1:0]))
      else $error("mask write not stored");

   a_mask_upper: assert property (@(posedge pclk) disable iff (!presetn)
      rd_done && hit_mask |-> prdata[31:`FLAG_W] == '0 && prdata[`FLAG_W-1:0] == mask_reg)
      else $error("mask readback wrong");

   a_autodone_rd: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !an_done |=> !autodone_reg && !status_word[`AUTODONE_BIT])
      else $error("done bit set while negotiation not done");

   a_speed_code: assert property (@(posedge pclk) disable iff (!presetn)
      ce && res_speed_100 && res_full_duplex |=> speed_reg == `SPEED_100_FULL)
      else $error("speed code wrong for 100 full duplex");

   a_ctl_field: assert property (@(posedge pclk) disable iff (!presetn)
      rd_done && hit_stat |-> prdata[`CTL_MSB:`CTL_LSB] == ctl_reg)
      else $error("status field readback wrong");

   a_stat_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      rd_done && hit_stat |-> prdata[31:`AUTODONE_BIT+1] == '0
                              && prdata[`SPEED_LSB-1:0] == '0)
      else $error("status reserved bits not zero");

   a_energy_drop: assert property (@(posedge pclk) disable iff (!presetn)
      ce && energy_reg && !energy_seen && quiet_cnt_reg == CNT_LAST |=> !energy_reg)
      else $error("energy indication did not drop after quiet window");

   a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
      ce && running && parallel_fault && mask_reg[`PARALLEL_DETECT_FAULT_FLAG_BIT]
      && !(wr_done && hit_mask)
      |=> phy_irq)
      else $error("unmasked event gave no interrupt");

   a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
      mask_reg == '0 |-> !phy_irq)
      else $error("interrupt high with all sources masked");

   a_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
      ce && running && rd_done && hit_flags && !page_received
      && prdata_reg[`PAGE_RECEIVED_FLAG_BIT]
      |=> !flags_reg[`PAGE_RECEIVED_FLAG_BIT])
      else $error("page flag not cleared by read");

   a_freeze_flags: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> flags_reg == $past(flags_reg))
      else $error("flags moved while clock enable low");

   a_freeze_mask: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> mask_reg == $past(mask_reg))
      else $error("mask moved while clock enable low");

   a_write_clear: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr_done && hit_flags && pstrb[0] && pwdata[`REMOTE_FAULT_FLAG_BIT]
      && !remote_fault |=> !flags_reg[`REMOTE_FAULT_FLAG_BIT])
      else $error("write one did not clear remote fault flag");

   a_setup_wait: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |-> !pready)
      else $error("ready high in setup cycle");

   a_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
      ce && psel && !penable && !loaded_reg ##1 ce |-> pready)
      else $error("access phase not answered at once");

   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      xfer_done |-> pslverr == !mapped)
      else $error("error response does not match address decode");

endmodule : phy_event_flag_mask_status

// [phy_event_flag_mask_status_bench.sv]
// Self-checking bench for the PHY event flag, mask and status block.
// Assumes the design files and mgmt_master are compiled before it.
`include "phy_event_defs.svh"

module phy_event_flag_mask_status_bench
   import phy_event_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int WIN = 16;
   localparam logic [7:0] A_FLG = {`IDX_EVENT_FLAGS, 2'b00};
   localparam logic [7:0] A_MSK = {`IDX_EVENT_MASK, 2'b00};
   localparam logic [7:0] A_STS = {`IDX_LINK_STATUS, 2'b00};
   // Flag bit of each source in src: remote, ack, parallel, page, done, link
   localparam int BITPOS [6] = '{5, 3, 2, 1, 6, 4};

   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, v, m;
   logic [3:0]  pstrb;
   logic [5:0]  src;
   logic [1:0]  res;
   logic        energy_seen, energy_present, phy_irq, err, ok;
   int          n_errors, checks;

   always #25 pclk = ~pclk;

   mgmt_master i_master (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                         .prdata, .pready, .pslverr);

   // Source vector keeps link_up active high while src[5] means link down
   phy_event_flag_mask_status #(.ADDR_W(8), .ENERGY_WINDOW_CYCLES(WIN)) i_dut (
      .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .energy_seen, .an_done(src[4]),
      .remote_fault(src[0]), .partner_ack(src[1]), .parallel_fault(src[2]),
      .page_received(src[3]), .link_up(~src[5]), .res_speed_100(res[0]),
      .res_full_duplex(res[1]), .energy_present, .phy_irq);

   function automatic logic [31:0] exp_status(input logic dn, input logic s1, input logic fd);
      return {19'h0, dn, 7'h02, fd, s1, ~s1, 2'b00};
   endfunction : exp_status

   task automatic results;
      $display("errors %0d, checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      i_master.xfer(wr, a, wd, rd, err, ok);
      if (ok !== 1'b1) begin
         n_errors++;
         $display("unexpected pready: expected 1, seen 0");
         results();
      end
   endtask : bus

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(what, exp, rd);
   endtask : rdchk

   // One-cycle source pulse, then let the flag settle before looking
   task automatic pulse(input int i);
      @(posedge pclk);
      src[i] <= 1'b1;
      @(posedge pclk);
      src[i] <= 1'b0;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask : pulse

   // Cuts a hang short
   initial begin
      repeat (50000) @(posedge pclk);
      n_errors++;
      $display("unexpected run length: expected end, seen timeout");
      results();
   end

   initial begin
      void'($urandom(32'h7a39));
      pclk = 1'b0;
      presetn = 1'b0;
      ce = 1'b1;
      energy_seen = 1'b1;
      src = 6'b10_0000;
      res = 2'b00;
      n_errors = 0;
      checks = 0;
      repeat (12) @(posedge pclk);
      chk("energy_present in reset", 32'h1, {31'h0, energy_present});
      presetn <= 1'b1;
      // Line down across reset: flag starts set and holds while cause stays
      rdchk("flags after reset", A_FLG, 32'h10);
      rdchk("flags link still down", A_FLG, 32'h10);
      src[5] <= 1'b0;
      rdchk("flags link back", A_FLG, 32'h10);
      rdchk("flags cleared", A_FLG, 32'h0);
      rdchk("mask reset", A_MSK, 32'h0);
      rdchk("status reset", A_STS, exp_status(1'b0, 1'b0, 1'b0));
      // Random low byte; software keeps the upper mask bits at zero
      for (int k = 0; k < 4; k++) begin
         v = $urandom & 32'h0000_00ff;
         bus(1'b1, A_MSK, v);
         rdchk("mask readback", A_MSK, v);
      end
      bus(1'b1, A_MSK, 32'hff);
      rdchk("mask all ones", A_MSK, 32'hff);
      // Every source but energy, first enabled then masked out
      for (int i = 0; i < 6; i++) begin
         m = 32'h1 << BITPOS[i];
         bus(1'b1, A_MSK, m);
         pulse(i);
         chk("irq enabled source", 32'h1, {31'h0, phy_irq});
         rdchk("flag set", A_FLG, m);
         rdchk("flag after read", A_FLG, 32'h0);
         bus(1'b1, A_MSK, ~m & 32'hff);
         pulse(i);
         chk("irq masked source", 32'h0, {31'h0, phy_irq});
         rdchk("flag set while masked", A_FLG, m);
      end
      src[4] <= 1'b1;
      repeat (3) @(posedge pclk);
      rdchk("negotiation flag", A_FLG, 32'h40);
      // All four resolved speed and duplex codes
      for (int s = 0; s < 4; s++) begin
         res <= s[1:0];
         repeat (3) @(posedge pclk);
         rdchk("status speed", A_STS, exp_status(1'b1, res[0], res[1]));
      end
      bus(1'b1, A_STS, 32'hffff_e043);
      rdchk("status reserved", A_STS, exp_status(1'b1, res[0], res[1]));
      // Quiet line drops energy, return of energy raises the flag
      energy_seen <= 1'b0;
      repeat (WIN + 4) @(posedge pclk);
      @(negedge pclk);
      chk("energy_present quiet", 32'h0, {31'h0, energy_present});
      bus(1'b1, A_MSK, 32'h80);
      energy_seen <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("irq energy", 32'h1, {31'h0, phy_irq});
      rdchk("energy flag", A_FLG, 32'h80);
      bus(1'b0, 8'h10, 32'h0);
      chk("pslverr unmapped read", 32'h1, {31'h0, err});
      chk("prdata unmapped read", 32'h0, rd);
      bus(1'b1, 8'h10, 32'hffff_ffff);
      chk("pslverr unmapped write", 32'h1, {31'h0, err});
      // Frozen block takes no event; write one clears like a read does
      ce <= 1'b0;
      pulse(2);
      @(posedge pclk);
      ce <= 1'b1;
      rdchk("flags after freeze", A_FLG, 32'h0);
      pulse(0);
      bus(1'b1, A_FLG, 32'h20);
      rdchk("flags after write one", A_FLG, 32'h0);
      // Second reset in mid-run with the link up
      bus(1'b1, A_MSK, 32'h5a);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("flags second reset", A_FLG, 32'h0);
      rdchk("mask second reset", A_MSK, 32'h0);
      results();
   end
endmodule : phy_event_flag_mask_status_bench

// [phy_event_pkg.sv]
// Types shared by the PHY event flag, mask and status block.
// Assumes the constants header sits in the same folder.
`include "phy_event_defs.svh"

package phy_event_pkg;

   // Start-up sequence: one cycle to capture the line state, then run
   typedef enum logic [1:0] {
      st_init = 2'b01,
      st_run  = 2'b10
   } run_state_t;

   typedef logic [`FLAG_W-1:0] flag_vec_t;

endpackage : phy_event_pkg
